// ==== rtl/ctrl_pkg.sv ====
// Shared constants and types of the exception and condition control core
package ctrl_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [4:0] OFS_INSTR  = 5'h00;
  localparam logic [4:0] OFS_PC     = 5'h04;
  localparam logic [4:0] OFS_PSW    = 5'h08;
  localparam logic [4:0] OFS_LINK   = 5'h0c;
  localparam logic [4:0] OFS_OP1    = 5'h10;
  localparam logic [4:0] OFS_OP2    = 5'h14;
  localparam logic [4:0] OFS_RESULT = 5'h18;
  localparam logic [4:0] OFS_STATUS = 5'h1c;

  // ****************************************
  // Status word fields and modes
  // ****************************************
  localparam int PSW_FLAGS_LSB = 28;
  localparam int PSW_IRQ_DIS   = 27;
  localparam int PSW_FIQ_DIS   = 26;
  localparam logic [1:0] MODE_USR = 2'h0;
  localparam logic [1:0] MODE_FIQ = 2'h1;
  localparam logic [1:0] MODE_IRQ = 2'h2;
  localparam logic [1:0] MODE_SVC = 2'h3;

  // ****************************************
  // Instruction fields
  // ****************************************
  localparam int COND_LSB = 28;
  localparam int IMM_BIT  = 25;
  localparam int LINK_BIT = 24;
  localparam int OPC_LSB  = 21;
  localparam int SET_BIT  = 20;

  // ****************************************
  // Exception kinds; the code times four is the vector
  // ****************************************
  localparam logic [2:0] EXC_RESET = 3'h0;
  localparam logic [2:0] EXC_UNDEF = 3'h1;
  localparam logic [2:0] EXC_SWI   = 3'h2;
  localparam logic [2:0] EXC_PABT  = 3'h3;
  localparam logic [2:0] EXC_DABT  = 3'h4;
  localparam logic [2:0] EXC_AEXC  = 3'h5;
  localparam logic [2:0] EXC_IRQ   = 3'h6;
  localparam logic [2:0] EXC_FIQ   = 3'h7;

  // Synchronised pin positions
  localparam int PIN_FIQ  = 0;
  localparam int PIN_IRQ  = 1;
  localparam int PIN_DABT = 2;
  localparam int PIN_AEXC = 3;
  localparam int PIN_PABT = 4;

  // ****************************************
  // Timing, in processor cycles (tenths where fractional)
  // ****************************************
  localparam int TSYNC_MAX_TENTHS = 25;
  localparam int TSYNC_MIN_TENTHS = 15;
  localparam int TLDM_CYCLES      = 18;
  localparam int TEXC_CYCLES      = 3;
  localparam int TINT_CYCLES      = 2;
  localparam int FIQ_MAX_TENTHS   = TSYNC_MAX_TENTHS + 10 * (TLDM_CYCLES + TEXC_CYCLES
                                    + TINT_CYCLES);
  localparam int IRQ_MIN_TENTHS   = TSYNC_MIN_TENTHS + 10 * TINT_CYCLES;
  localparam logic [1:0] ENTRY_LAST_EXC = 2'(TEXC_CYCLES - 1);
  localparam logic [1:0] ENTRY_LAST_INT = 2'(TINT_CYCLES - 1);

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_EXEC  = 4'h2,
    S_COP   = 4'h4,
    S_ENTRY = 4'h8
  } fsm_t;

endpackage

// ==== rtl/exec_if.sv ====
// Carrier between the control core and its condition and ALU units
`timescale 1ns/1ps
interface exec_if;
  logic [31:0] instr;
  logic [31:0] op1;
  logic [31:0] op2_reg;
  logic [3:0]  flags;
  logic        cond_pass;
  logic [31:0] result;
  logic [3:0]  res_flags;
  logic        write_rd;
  logic        set_flags;

  modport core (output instr, op1, op2_reg, flags,
                input  cond_pass, result, res_flags, write_rd, set_flags);
  modport cond_side (input instr, flags, output cond_pass);
  modport alu_side (input  instr, op1, op2_reg, flags,
                    output result, res_flags, write_rd, set_flags);
endinterface

// ==== rtl/cond_check.sv ====
// Condition field evaluation against the stored flags
`timescale 1ns/1ps
module cond_check (
  // Instruction and flags in, verdict out
  exec_if.cond_side ex
);

  // Flags are packed N, Z, C, V from bit 3 down
  function automatic logic pass_f(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cf;
    logic v;
    n  = f[3];
    z  = f[2];
    cf = f[1];
    v  = f[0];
    case (c)
      4'h0:    pass_f = z;
      4'h1:    pass_f = !z;
      4'h2:    pass_f = cf;
      4'h3:    pass_f = !cf;
      4'h4:    pass_f = n;
      4'h5:    pass_f = !n;
      4'h6:    pass_f = v;
      4'h7:    pass_f = !v;
      4'h8:    pass_f = cf && !z;
      4'h9:    pass_f = !cf || z;
      4'ha:    pass_f = n == v;
      4'hb:    pass_f = n != v;
      4'hc:    pass_f = !z && (n == v);
      4'hd:    pass_f = z || (n != v);
      4'he:    pass_f = 1'b1;
      default: pass_f = 1'b0;
    endcase
  endfunction

  assign ex.cond_pass = pass_f(ex.instr[31:ctrl_pkg::COND_LSB], ex.flags);

endmodule

// ==== rtl/alu_decode.sv ====
// Operand selection, ALU result and flag outcome for data instructions
`timescale 1ns/1ps
module alu_decode (
  // Operands and instruction in, result and flags out
  exec_if.alu_side ex
);

  function automatic logic [32:0] add33(input logic [31:0] a, input logic [31:0] b,
                                        input logic ci);
    add33 = {1'b0, a} + {1'b0, b} + {32'h0, ci};
  endfunction

  logic [31:0] op2;
  logic [31:0] imm;
  logic [31:0] a;
  logic [31:0] b;
  logic        ci;
  logic        arith;
  logic [31:0] lres;
  logic [32:0] sum;
  logic [31:0] res;
  logic [3:0]  opc;
  logic        cf;

  assign opc = ex.instr[ctrl_pkg::OPC_LSB +: 4];
  assign cf  = ex.flags[1];
  // Shifter is not modelled: a register operand passes unshifted
  assign imm = {24'h0, ex.instr[7:0]};
  assign op2 = ex.instr[ctrl_pkg::IMM_BIT] ?
               ((imm >> {ex.instr[11:8], 1'b0}) | (imm << (6'h20 - {1'b0, ex.instr[11:8], 1'b0})))
               : ex.op2_reg;

  always_comb begin
    a     = ex.op1;
    b     = op2;
    ci    = 1'b0;
    arith = 1'b1;
    lres  = '0;
    case (opc)
      4'h0, 4'h8: begin arith = 1'b0; lres = ex.op1 & op2; end
      4'h1, 4'h9: begin arith = 1'b0; lres = ex.op1 ^ op2; end
      4'h2, 4'ha: begin b = ~op2; ci = 1'b1; end
      4'h3:       begin a = op2; b = ~ex.op1; ci = 1'b1; end
      4'h5:       ci = cf;
      4'h6:       begin b = ~op2; ci = cf; end
      4'h7:       begin a = op2; b = ~ex.op1; ci = cf; end
      4'hc:       begin arith = 1'b0; lres = ex.op1 | op2; end
      4'hd:       begin arith = 1'b0; lres = op2; end
      4'he:       begin arith = 1'b0; lres = ex.op1 & ~op2; end
      4'hf:       begin arith = 1'b0; lres = ~op2; end
      default:    ci = 1'b0; // Add and add-compare
    endcase
    sum = add33(a, b, ci);
    res = arith ? sum[31:0] : lres;
  end

  assign ex.result       = res;
  assign ex.res_flags[3] = res[31];
  assign ex.res_flags[2] = res == 32'h0;
  // Logical class keeps C since no shift carry exists here, and always keeps V
  assign ex.res_flags[1] = arith ? sum[32] : cf;
  assign ex.res_flags[0] = arith ? ((a[31] == b[31]) && (sum[31] != a[31])) : ex.flags[0];
  assign ex.write_rd     = opc[3:2] != 2'b10;
  assign ex.set_flags    = ex.instr[ctrl_pkg::SET_BIT];

endmodule

// ==== rtl/exception_condition_branch_ctrl.sv ====
// Exception, condition, branch and ALU control core with a Wishbone register port
// ****************************************
// What this block does
// - Reset is serviced before every other exception.
// - Then address/data abort, fast interrupt, interrupt, prefetch abort, undefined/trap.
// - Each exception loads its fixed vector, code times four, 0x00 to 0x1c.
// - An accepted but busy coprocessor stalls the core until ready.
// - With no coprocessor accepting, take the undefined trap returning to next instruction.
// - While reset is held, nothing executes and no state changes.
// - Reset release runs the reset entry; there is no return from it.
// - Address/data abort with enabled fast interrupt: abort entry, then fast interrupt entry.
// - Worst fast interrupt latency: 2.5 + 18 + 3 + 2 cycles.
// - Least interrupt recognition delay: synchroniser minimum plus entry, 3.5 cycles.
// - Code 0000 executes only with zero set.
// - Code 1000 carry set and zero clear; 1001 the complement.
// - Code 1101 passes on zero set or negative differing from overflow.
// - Code 1111 is a one-cycle no-op; 1110 always executes.
// - Branch adds the sign-extended 24-bit offset shifted by two, wrapping.
// - Branch base is the program counter plus two words.
// - Branch-and-link saves counter and flags in the current mode's link register.
// - Saved link address is the instruction after the branch.
// - First operand is a register; immediate bit picks register or rotated immediate.
// - Flags change only when the flag-update bit is set.
// - Test and compare operations never write the destination.
// - Opcodes 1000 to 1011 are AND, XOR, subtract and add tests.
// ****************************************
`timescale 1ns/1ps
module exception_condition_branch_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Exception request pins
  input  wire logic        fast_interrupt_n_i,
  input  wire logic        irq_n_i,
  input  wire logic        data_abort_i,
  input  wire logic        addr_exc_i,
  input  wire logic        prefetch_abort_i,
  // Coprocessor offer
  input  wire logic        cop_accept_i,
  input  wire logic        cop_busy_i,
  output logic             cop_offer_o,
  // Processor mode
  output logic      [1:0]  mode_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    ctrl_pkg::fsm_t  fsm;
    logic            ack;
    logic [31:0]     rdat;
    logic [31:0]     instr;
    logic [31:0]     pc;
    logic [3:0][31:0] link;
    logic [31:0]     op1;
    logic [31:0]     op2;
    logic [31:0]     result;
    logic [3:0]      nzcv;
    logic            irq_dis;
    logic            fiq_dis;
    logic [1:0]      mode;
    logic [2:0]      kind;
    logic [1:0]      cnt;
    logic            offer;
    logic            pend_dabt;
    logic            pend_aexc;
    logic [4:0]      s1;
    logic [4:0]      s2;
    logic [4:0]      s3;
    logic [4:0]      filt;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = sel[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ****************************************
  // Condition and ALU units
  // ****************************************
  exec_if ex ();

  assign ex.instr   = st_reg.instr;
  assign ex.op1     = st_reg.op1;
  assign ex.op2_reg = st_reg.op2;
  assign ex.flags   = st_reg.nzcv;

  cond_check u_cond (
    .ex (ex)
  );

  alu_decode u_alu (
    .ex (ex)
  );

  // ****************************************
  // Combinational helpers
  // ****************************************
  logic [4:0]  pins;
  logic        req;
  logic [4:0]  rise;
  logic        fiq_act;
  logic        irq_act;
  logic        take;
  logic [2:0]  take_kind;
  logic [31:0] ret_pc;
  logic [31:0] link_word;
  logic [31:0] br_off;
  logic [31:0] psw_word;
  logic [31:0] wr;
  logic        ent_go;
  logic [2:0]  ent_kind;
  logic [1:0]  ent_last;
  logic [1:0]  new_mode;

  assign pins = {prefetch_abort_i, addr_exc_i, data_abort_i, ~irq_n_i, ~fast_interrupt_n_i};
  assign req  = wb_cyc_i & wb_stb_i & ~st_reg.ack;

  assign ret_pc    = st_reg.pc + 32'h4;
  assign link_word = {st_reg.nzcv, st_reg.irq_dis, st_reg.fiq_dis, ret_pc[25:2],
                      st_reg.mode};
  assign br_off    = {{6{st_reg.instr[23]}}, st_reg.instr[23:0], 2'b00};
  assign psw_word  = {st_reg.nzcv, st_reg.irq_dis, st_reg.fiq_dis, 24'h0, st_reg.mode};

  always_comb begin
    st_next = st_reg;
    ent_go  = 1'b0;
    ent_kind = ctrl_pkg::EXC_UNDEF;
    wr      = '0;
    ent_last = ctrl_pkg::ENTRY_LAST_EXC;
    new_mode = ctrl_pkg::MODE_SVC;

    // Three-stage pin synchroniser; a level counts once stages two and three agree
    st_next.s1   = pins;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.filt = (st_reg.s2 & st_reg.s3) | (st_reg.filt & (st_reg.s2 ^ st_reg.s3));
    rise = st_next.filt & ~st_reg.filt;

    // Aborts are events, so they are kept until their entry starts
    st_next.pend_dabt = st_reg.pend_dabt | rise[ctrl_pkg::PIN_DABT];
    st_next.pend_aexc = st_reg.pend_aexc | rise[ctrl_pkg::PIN_AEXC];

    // Interrupts are levels; the requester keeps them up until serviced
    fiq_act = st_next.filt[ctrl_pkg::PIN_FIQ] & ~st_reg.fiq_dis;
    irq_act = st_next.filt[ctrl_pkg::PIN_IRQ] & ~st_reg.irq_dis;

    // Fixed priority below reset; a fresh abort edge beats a same-cycle interrupt
    take = 1'b1;
    if (st_next.pend_aexc) begin
      take_kind = ctrl_pkg::EXC_AEXC;
    end else if (st_next.pend_dabt) begin
      take_kind = ctrl_pkg::EXC_DABT;
    end else if (fiq_act) begin
      take_kind = ctrl_pkg::EXC_FIQ;
    end else if (irq_act) begin
      take_kind = ctrl_pkg::EXC_IRQ;
    end else begin
      take      = 1'b0;
      take_kind = ctrl_pkg::EXC_IRQ;
    end

    // ****************************************
    // Wishbone register access
    // ****************************************
    st_next.ack  = req;
    st_next.rdat = '0;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        ctrl_pkg::OFS_INSTR:  st_next.rdat = st_reg.instr;
        ctrl_pkg::OFS_PC:     st_next.rdat = st_reg.pc;
        ctrl_pkg::OFS_PSW:    st_next.rdat = psw_word;
        ctrl_pkg::OFS_LINK:   st_next.rdat = st_reg.link[st_reg.mode];
        ctrl_pkg::OFS_OP1:    st_next.rdat = st_reg.op1;
        ctrl_pkg::OFS_OP2:    st_next.rdat = st_reg.op2;
        ctrl_pkg::OFS_RESULT: st_next.rdat = st_reg.result;
        ctrl_pkg::OFS_STATUS: st_next.rdat = {17'h0, st_reg.fsm, st_reg.kind, st_reg.offer,
                                              st_reg.pend_dabt, st_reg.pend_aexc,
                                              st_reg.filt};
        default:              st_next.rdat = '0;
      endcase
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        ctrl_pkg::OFS_INSTR: begin
          // A new instruction is only taken while the core is idle
          if (st_reg.fsm == ctrl_pkg::S_IDLE) begin
            st_next.instr = wmerge(st_reg.instr, wb_dat_i, wb_sel_i);
            st_next.fsm   = ctrl_pkg::S_EXEC;
          end
        end
        ctrl_pkg::OFS_PC:   st_next.pc = wmerge(st_reg.pc, wb_dat_i, wb_sel_i);
        ctrl_pkg::OFS_PSW: begin
          wr = wmerge(psw_word, wb_dat_i, wb_sel_i);
          st_next.nzcv    = wr[31:ctrl_pkg::PSW_FLAGS_LSB];
          st_next.irq_dis = wr[ctrl_pkg::PSW_IRQ_DIS];
          st_next.fiq_dis = wr[ctrl_pkg::PSW_FIQ_DIS];
          st_next.mode    = wr[1:0];
        end
        ctrl_pkg::OFS_LINK:
          st_next.link[st_reg.mode] = wmerge(st_reg.link[st_reg.mode], wb_dat_i, wb_sel_i);
        ctrl_pkg::OFS_OP1:  st_next.op1 = wmerge(st_reg.op1, wb_dat_i, wb_sel_i);
        ctrl_pkg::OFS_OP2:  st_next.op2 = wmerge(st_reg.op2, wb_dat_i, wb_sel_i);
        default:            wr = '0;
      endcase
    end

    // ****************************************
    // Sequencer
    // ****************************************
    case (st_reg.fsm)
      ctrl_pkg::S_IDLE: begin
        if (take) begin
          ent_go   = 1'b1;
          ent_kind = take_kind;
        end
      end
      ctrl_pkg::S_EXEC: begin
        // The offered instruction is abandoned when an exception is taken first
        st_next.fsm = ctrl_pkg::S_IDLE;
        if (take) begin
          ent_go   = 1'b1;
          ent_kind = take_kind;
        end else if (st_reg.filt[ctrl_pkg::PIN_PABT]) begin
          ent_go   = 1'b1;
          ent_kind = ctrl_pkg::EXC_PABT;
        end else if (!ex.cond_pass) begin
          st_next.pc = ret_pc;
        end else if (st_reg.instr[27:24] == 4'hf) begin
          ent_go   = 1'b1;
          ent_kind = ctrl_pkg::EXC_SWI;
        end else if (st_reg.instr[27:25] == 3'b101) begin
          if (st_reg.instr[ctrl_pkg::LINK_BIT]) begin
            st_next.link[st_reg.mode] = link_word;
          end
          st_next.pc = st_reg.pc + 32'h8 + br_off;
        end else if (st_reg.instr[27:26] == 2'b00) begin
          if (ex.write_rd) begin
            st_next.result = ex.result;
          end
          if (ex.set_flags) begin
            st_next.nzcv = ex.res_flags;
          end
          st_next.pc = ret_pc;
        end else if (st_reg.instr[27:26] == 2'b11 ||
                     (st_reg.instr[27:25] == 3'b011 && st_reg.instr[4])) begin
          st_next.offer = 1'b1;
          st_next.fsm   = ctrl_pkg::S_COP;
        end else begin
          // Transfers are handled elsewhere; here they only advance the counter
          st_next.pc = ret_pc;
        end
      end
      ctrl_pkg::S_COP: begin
        if (!cop_accept_i) begin
          st_next.offer = 1'b0;
          ent_go        = 1'b1;
          ent_kind      = ctrl_pkg::EXC_UNDEF;
        end else if (!cop_busy_i) begin
          st_next.offer = 1'b0;
          st_next.pc    = ret_pc;
          st_next.fsm   = ctrl_pkg::S_IDLE;
        end
      end
      ctrl_pkg::S_ENTRY: begin
        ent_last = (st_reg.kind == ctrl_pkg::EXC_FIQ || st_reg.kind == ctrl_pkg::EXC_IRQ) ?
                   ctrl_pkg::ENTRY_LAST_INT : ctrl_pkg::ENTRY_LAST_EXC;
        if (st_reg.cnt == ent_last) begin
          case (st_reg.kind)
            ctrl_pkg::EXC_FIQ: new_mode = ctrl_pkg::MODE_FIQ;
            ctrl_pkg::EXC_IRQ: new_mode = ctrl_pkg::MODE_IRQ;
            default:           new_mode = ctrl_pkg::MODE_SVC;
          endcase
          st_next.link[new_mode] = link_word;
          st_next.mode           = new_mode;
          st_next.irq_dis        = 1'b1;
          if (st_reg.kind == ctrl_pkg::EXC_RESET || st_reg.kind == ctrl_pkg::EXC_FIQ) begin
            st_next.fiq_dis = 1'b1;
          end
          // Abort entry leaves the fast interrupt enabled, so it follows at once
          st_next.pc  = {27'h0, st_reg.kind, 2'b00};
          st_next.fsm = ctrl_pkg::S_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt + 2'h1;
        end
      end
      default: st_next.fsm = ctrl_pkg::S_IDLE;
    endcase

    if (ent_go) begin
      st_next.fsm  = ctrl_pkg::S_ENTRY;
      st_next.kind = ent_kind;
      st_next.cnt  = '0;
      // Set wins: a new abort edge in this cycle stays pending
      if (ent_kind == ctrl_pkg::EXC_AEXC) begin
        st_next.pend_aexc = st_reg.pend_aexc & rise[ctrl_pkg::PIN_AEXC];
      end
      if (ent_kind == ctrl_pkg::EXC_DABT) begin
        st_next.pend_dabt = st_reg.pend_dabt & rise[ctrl_pkg::PIN_DABT];
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg      <= '0;
      st_reg.fsm  <= ctrl_pkg::S_ENTRY;
      st_reg.kind <= ctrl_pkg::EXC_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o    = st_reg.rdat;
  assign wb_ack_o    = st_reg.ack;
  assign cop_offer_o = st_reg.offer;
  assign mode_o      = st_reg.mode;

endmodule

// ==== bench/cop_model.sv ====
// Coprocessor stand-in facing the offer port
`timescale 1ns/1ps
module cop_model (
  // Offer in, answer out
  input  wire logic       clk_i,
  input  wire logic       offer_i,
  input  wire logic       present_i,
  input  wire logic [3:0] busy_len_i,
  output logic            accept_o,
  output logic            busy_o
);
  logic [3:0] cnt = 4'h0;
  logic       tgl = 1'b0;
  // Outside an offer the answers flip each cycle so nothing leans on them
  always_ff @(posedge clk_i) begin
    tgl <= ~tgl;
    cnt <= offer_i ? cnt + 4'h1 : 4'h0;
  end
  assign accept_o = offer_i ? present_i : tgl;
  assign busy_o   = offer_i ? (present_i && cnt < busy_len_i) : ~tgl;
endmodule

// ==== bench/exception_condition_branch_ctrl_sva.sv ====
// Port assertions for the control core
`timescale 1ns/1ps
module ctrl_sva (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins, coprocessor and mode
  input wire logic        fast_interrupt_n_i,
  input wire logic        irq_n_i,
  input wire logic        data_abort_i,
  input wire logic        addr_exc_i,
  input wire logic        prefetch_abort_i,
  input wire logic        cop_accept_i,
  input wire logic        cop_busy_i,
  input wire logic        cop_offer_o,
  input wire logic [1:0]  mode_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !wb_ack_o && !cop_offer_o && mode_o == 2'h0) else $error("activity in reset");
  a_reset_entry: assert property ($fell(rst_i) |-> ##[1:8] mode_o == 2'h3)
    else $error("no reset entry");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  a_busy_stall: assert property (cop_offer_o && cop_accept_i && cop_busy_i |=> cop_offer_o)
    else $error("busy not waited");
  a_no_taker: assert property (cop_offer_o && !cop_accept_i |=> !cop_offer_o)
    else $error("offer kept");
  a_undef_mode: assert property (cop_offer_o && !cop_accept_i |-> ##[1:6] mode_o == 2'h3)
    else $error("no undefined entry");
  a_fiq_lag: assert property ($changed(mode_o) && mode_o == ctrl_pkg::MODE_FIQ |->
    $past(fast_interrupt_n_i, 3) == 1'b0) else $error("fast entry too early");
endmodule
bind exception_condition_branch_ctrl ctrl_sva ctrl_sva_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .fast_interrupt_n_i(fast_interrupt_n_i), .irq_n_i(irq_n_i), .data_abort_i(data_abort_i),
  .addr_exc_i(addr_exc_i), .prefetch_abort_i(prefetch_abort_i), .cop_accept_i(cop_accept_i),
  .cop_busy_i(cop_busy_i), .cop_offer_o(cop_offer_o), .mode_o(mode_o));

// ==== bench/test_exception_condition_branch_ctrl.sv ====
// Self-checking bench for the control core
`timescale 1ns/1ps
module test_exception_condition_branch_ctrl;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic [4:0]  adr     = 5'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] rdo;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  pins    = 4'h3;
  logic        present = 1'b0;
  logic        pabt    = 1'b0;
  logic [3:0]  blen    = 4'h3;
  logic        offer;
  logic        acc;
  logic        busy;
  logic [1:0]  mode;
  int          n_fail  = 0;
  int          checked = 0;
  always #5 clk_i = ~clk_i;
  exception_condition_branch_ctrl exception_condition_branch_ctrl_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack),
    .fast_interrupt_n_i(pins[0]), .irq_n_i(pins[1]), .data_abort_i(pins[2]),
    .addr_exc_i(pins[3]), .prefetch_abort_i(pabt), .cop_accept_i(acc), .cop_busy_i(busy),
    .cop_offer_o(offer), .mode_o(mode));
  cop_model cop_model_i (.clk_i(clk_i), .offer_i(offer), .present_i(present),
    .busy_len_i(blen), .accept_o(acc), .busy_o(busy));
  // ****
  // Tasks
  // ****
  task end_sim;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = rdo;
    cyc <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      end_sim;
    end
  endtask
  task idle;
    int n;
    n = 0;
    do begin
      wb(1'b0, ctrl_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (rdat[14:11] !== ctrl_pkg::S_IDLE && n < 30);
    if (rdat[14:11] !== ctrl_pkg::S_IDLE) begin
      n_fail++;
      end_sim;
    end
  endtask
  function automatic logic ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      default: r = 1'b1;
    endcase
    return (c == 4'hf) ? 1'b0 : r ^ c[0];
  endfunction
  task cop(input logic p, input logic [31:0] ins, input logic [31:0] exp);
    present <= p;
    wb(1'b1, ctrl_pkg::OFS_PC, 32'h300);
    wb(1'b1, ctrl_pkg::OFS_INSTR, ins);
    idle;
    wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
    chk(rdat, exp, "coprocessor pc");
  endtask
  task exc(input logic [3:0] p, input logic [1:0] m, input logic v, input logic [31:0] pc);
    logic saw;
    int n;
    wb(1'b1, ctrl_pkg::OFS_PSW, 32'h0);
    saw = 1'b0;
    n = 0;
    pins <= p;
    while (mode !== m && n < 80) begin
      @(posedge clk_i);
      n++;
      saw |= (mode === 2'h3);
    end
    pins <= 4'h3;
    if (n >= 80) begin
      n_fail++;
      end_sim;
    end
    idle;
    wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
    chk(rdat, pc, "vector");
    chk(32'(saw), 32'(v), "abort first");
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    idle;
    wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
    chk(rdat, 32'h0, "reset pc");
    wb(1'b0, ctrl_pkg::OFS_PSW, 32'h0);
    chk(32'({rdat[27:26], rdat[1:0]}), 32'hf, "reset status");
    for (int i = 0; i < 256; i++) begin
      wb(1'b1, ctrl_pkg::OFS_PC, 32'h100);
      wb(1'b1, ctrl_pkg::OFS_PSW, {i[3:0], 28'hc000003});
      wb(1'b1, ctrl_pkg::OFS_INSTR, {i[7:4], 28'ha000000});
      idle;
      wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
      chk(rdat, ok(i[7:4], i[3:0]) ? 32'h108 : 32'h104, "cond pc");
    end
    $display("test conditions done");
    wb(1'b1, ctrl_pkg::OFS_PC, 32'h200);
    wb(1'b1, ctrl_pkg::OFS_PSW, 32'h9c000003);
    wb(1'b1, ctrl_pkg::OFS_INSTR, 32'hebffffff);
    idle;
    wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
    chk(rdat, 32'h204, "link branch pc");
    wb(1'b0, ctrl_pkg::OFS_LINK, 32'h0);
    chk(rdat, 32'h9c000207, "link word");
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, ctrl_pkg::OFS_OP1, 32'h5);
      wb(1'b1, ctrl_pkg::OFS_OP2, 32'h5);
      wb(1'b1, ctrl_pkg::OFS_PSW, 32'h0c000003);
      wb(1'b1, ctrl_pkg::OFS_INSTR, {8'he1, 1'b0, k[1:0], 1'b1, 20'h0});
      idle;
      wb(1'b0, ctrl_pkg::OFS_PSW, 32'h0);
      chk(32'(rdat[31:28]), 32'((16'h0640 >> (4 * k)) & 16'hf), "test flags");
      wb(1'b0, ctrl_pkg::OFS_RESULT, 32'h0);
      chk(rdat, 32'h0, "test result");
    end
    wb(1'b1, ctrl_pkg::OFS_PSW, 32'hac000003);
    wb(1'b1, ctrl_pkg::OFS_INSTR, 32'he2800101);
    idle;
    wb(1'b1, ctrl_pkg::OFS_RESULT, 32'h0);
    wb(1'b0, ctrl_pkg::OFS_RESULT, 32'h0);
    chk(rdat, 32'h40000005, "imm result");
    wb(1'b0, ctrl_pkg::OFS_PSW, 32'h0);
    chk(32'(rdat[31:28]), 32'ha, "kept flags");
    $display("test branch and alu done");
    cop(1'b1, 32'hee000000, 32'h304);
    cop(1'b0, 32'hee000000, 32'h4);
    cop(1'b0, 32'hef000000, 32'h8);
    pabt <= 1'b1;
    cop(1'b0, 32'he1a00000, 32'hc);
    pabt <= 1'b0;
    exc(4'h9, 2'h3, 1'b1, 32'h14);
    exc(4'h6, 2'h1, 1'b1, 32'h1c);
    exc(4'h0, 2'h1, 1'b0, 32'h1c);
    exc(4'h1, 2'h2, 1'b0, 32'h18);
    $display("test traps done");
    present <= 1'b1;
    blen <= 4'hf;
    wb(1'b1, ctrl_pkg::OFS_INSTR, 32'hee000000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    pins <= 4'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    idle;
    pins <= 4'h3;
    wb(1'b0, ctrl_pkg::OFS_PC, 32'h0);
    chk(rdat, 32'h0, "reset wins");
    $display("test reset done");
    end_sim;
  end
endmodule
